// ==== asirc_pkg.sv ====
// constants and register map of the light-sensor configuration and interrupt registers
package asirc_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE      = 8'h80;
    localparam logic [7:0] ADDR_STATUS      = 8'h93;
    localparam logic [7:0] ADDR_CONFIG3     = 8'hab;
    localparam logic [7:0] ADDR_AUTOZERO    = 8'hd6;
    localparam logic [7:0] ADDR_INT_ENABLE  = 8'hdd;
    localparam logic [7:0] ADDR_VIS_SCALE   = 8'he6;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_POWER_ON       = 0;
    localparam int BIT_READ_CLEAR     = 7;
    localparam int BIT_SLEEP_AFTER    = 4;
    localparam int BIT_SAT_IRQ_EN     = 7;
    localparam int BIT_PROX_IRQ_EN    = 5;
    localparam int BIT_ALS_IRQ_EN     = 4;
    localparam int BIT_SAT_FLAG       = 7;
    localparam int BIT_PROX_FLAG      = 5;
    localparam int BIT_ALS_FLAG       = 4;
    localparam int BIT_CAL_FLAG       = 3;
    localparam int AZ_MSB             = 6;

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE       = 8'h00;
    localparam logic [7:0] RST_CONFIG3      = 8'h4c;
    localparam logic [7:0] RST_AUTOZERO     = 8'h7f;
    localparam logic [7:0] RST_INT_ENABLE   = 8'h00;
    localparam logic [7:0] RST_STATUS       = 8'h00;
    localparam logic [7:0] STATUS_FLAG_MASK = 8'hb8;
    localparam logic [7:0] ENABLE_MASK      = 8'h01;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // ----------------------------------------------------------------
    // autozero interval codes
    // ----------------------------------------------------------------
    localparam logic [6:0] AZ_NEVER         = 7'h00;
    localparam logic [6:0] AZ_FIRST_ONLY    = 7'h7f;
    localparam logic [6:0] AZ_COUNT_ZERO    = 7'h00;
    localparam logic [6:0] AZ_COUNT_ONE     = 7'h01;

    // factory scale value, sign in bit 7, percent in bits 6:0
    localparam logic [7:0] VIS_SCALE_DEFAULT = 8'h94;

    typedef enum logic [0:0] {
        ASIRC_RUN,
        ASIRC_ASLEEP
    } asirc_power_type;

endpackage : asirc_pkg

// ==== asirc_irq_if.sv ====
// signals between the register bank and its interrupt and sleep controller
`timescale 1ns/1ps
`default_nettype none
interface asirc_irq_if;
    logic       als_flag;
    logic       prox_flag;
    logic       sat_flag;
    logic       als_en;
    logic       prox_en;
    logic       sat_en;
    logic       sleep_after;
    logic       power_on;
    logic       cycle_done;
    logic       irq_active;
    logic       osc_enable;
    logic       asleep;

    modport bank (
        output als_flag, prox_flag, sat_flag, als_en, prox_en, sat_en,
               sleep_after, power_on, cycle_done,
        input  irq_active, osc_enable, asleep
    );
    modport ctrl (
        input  als_flag, prox_flag, sat_flag, als_en, prox_en, sat_en,
               sleep_after, power_on, cycle_done,
        output irq_active, osc_enable, asleep
    );
endinterface : asirc_irq_if
`default_nettype wire

// ==== asirc_irq_sleep.sv ====
// interrupt combining and sleep-after-interrupt oscillator control
`timescale 1ns/1ps
`default_nettype none
module asirc_irq_sleep (
    input  wire logic   mclk,
    input  wire logic   arst_n,
    asirc_irq_if.ctrl   irq
);

    asirc_pkg::asirc_power_type state_reg;
    asirc_pkg::asirc_power_type state_next;

    // ----------------------------------------------------------------
    // interrupt combine
    // ----------------------------------------------------------------
    // flag and enable pairs
    assign irq.irq_active = (irq.als_flag & irq.als_en)
                          | (irq.prox_flag & irq.prox_en)
                          | (irq.sat_flag & irq.sat_en);

    // ----------------------------------------------------------------
    // sleep state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            asirc_pkg::ASIRC_RUN:
            begin
                if (irq.cycle_done && irq.sleep_after && irq.irq_active && irq.power_on)
                    state_next = asirc_pkg::ASIRC_ASLEEP;
            end
            asirc_pkg::ASIRC_ASLEEP:
            begin
                // clearing flags or their enables wakes; power-off also resets the state
                if (!irq.irq_active || !irq.power_on)
                    state_next = asirc_pkg::ASIRC_RUN;
            end
            default:
                state_next = asirc_pkg::ASIRC_RUN;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= asirc_pkg::ASIRC_RUN;
        else
            state_reg <= state_next;
    end

    assign irq.asleep = (state_reg == asirc_pkg::ASIRC_ASLEEP);
    assign irq.osc_enable = irq.power_on & ~irq.asleep;

endmodule : asirc_irq_sleep
`default_nettype wire

// ==== asirc_regs.sv ====
// configuration and interrupt-control register bank of a two-channel light sensor
//
// Summary of operation
// - with clear-by-read set, a status read clears every status flag.
// - interrupt asserts on als flag with enable, or prox flag with enable.
// - sleep-after-interrupt set plus asserted interrupt stops the oscillator.
// - the sleep decision is taken when a measurement cycle completes.
// - while asleep the device acts powered off but power-on reads 1.
// - clearing status flags or their interrupt enables re-enables the oscillator; host must clear.
// - autozero interval: 0 never, n every nth cycle, 7fh first only.
// - autozero interval resets to all ones.
// - interrupt-enable bit 7 gates saturation interrupts, reset disabled.
// - visible scale factor is read-only, factory set, sign-magnitude percent.
// - writing one to a status bit clears that flag.
// - als flag sets on threshold-and-persistence event.
// - saturation flag sets when the analog front end saturates.
`timescale 1ns/1ps
`default_nettype none
module asirc_regs #(
    parameter logic [7:0] VIS_SCALE = asirc_pkg::VIS_SCALE_DEFAULT
) (
    input  wire logic          mclk,
    input  wire logic          arst_n,
    // register port from the serial-bus slave engine
    input  wire logic          reg_wr_stb,
    input  wire logic          reg_rd_stb,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata,
    // events from the measurement core
    input  wire logic          als_thresh_evt,
    input  wire logic          prox_thresh_evt,
    input  wire logic          afe_sat_evt,
    input  wire logic          cal_done_evt,
    input  wire logic          meas_cycle_done,
    input  wire logic          als_cycle_start,
    // controls back to the core and pin
    output logic               autozero_req,
    output logic               osc_enable,
    output logic               int_pin_out,
    output logic               int_pin_oe_n
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] enable_reg;
    logic [7:0] config_three_reg;
    logic [7:0] autozero_config_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [6:0] az_count_reg;
    logic [6:0] az_count_next;
    logic       az_first_reg;
    logic       az_req_reg;
    logic       az_req_next;

    asirc_irq_if irq ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire wr_enable   = reg_wr_stb & hit(reg_addr, asirc_pkg::ADDR_ENABLE);
    wire wr_config3  = reg_wr_stb & hit(reg_addr, asirc_pkg::ADDR_CONFIG3);
    wire wr_autozero = reg_wr_stb & hit(reg_addr, asirc_pkg::ADDR_AUTOZERO);
    wire wr_int_en   = reg_wr_stb & hit(reg_addr, asirc_pkg::ADDR_INT_ENABLE);
    wire wr_status   = reg_wr_stb & hit(reg_addr, asirc_pkg::ADDR_STATUS);
    wire rd_status   = reg_rd_stb & hit(reg_addr, asirc_pkg::ADDR_STATUS);

    wire        power_on    = enable_reg[asirc_pkg::BIT_POWER_ON];
    wire        read_clear  = config_three_reg[asirc_pkg::BIT_READ_CLEAR];
    wire [6:0]  az_interval = autozero_config_reg[asirc_pkg::AZ_MSB:0];

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // interval resets to all ones
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enable_reg           <= asirc_pkg::RST_ENABLE;
            config_three_reg     <= asirc_pkg::RST_CONFIG3;
            autozero_config_reg  <= asirc_pkg::RST_AUTOZERO;
            interrupt_enable_reg <= asirc_pkg::RST_INT_ENABLE;
        end
        else
        begin
            if (wr_enable)
                enable_reg <= reg_wdata & asirc_pkg::ENABLE_MASK;
            if (wr_config3)
                config_three_reg <= reg_wdata;
            if (wr_autozero)
                autozero_config_reg <= reg_wdata;
            if (wr_int_en)
                interrupt_enable_reg <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // set wins over clear so an event in the clearing cycle survives
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    always_comb
    begin
        flag_set = asirc_pkg::READ_ZERO;
        flag_set[asirc_pkg::BIT_ALS_FLAG]  = als_thresh_evt;
        flag_set[asirc_pkg::BIT_PROX_FLAG] = prox_thresh_evt;
        flag_set[asirc_pkg::BIT_SAT_FLAG]  = afe_sat_evt;
        flag_set[asirc_pkg::BIT_CAL_FLAG]  = cal_done_evt;
        flag_clr = asirc_pkg::READ_ZERO;
        if (wr_status)
            flag_clr = reg_wdata;
        if (rd_status && read_clear)
            flag_clr = asirc_pkg::STATUS_FLAG_MASK;
        status_next = ((status_reg & ~flag_clr) | flag_set) & asirc_pkg::STATUS_FLAG_MASK;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            status_reg <= asirc_pkg::RST_STATUS;
        else
            status_reg <= status_next;
    end

    // ----------------------------------------------------------------
    // interrupt and sleep controller
    // ----------------------------------------------------------------
    assign irq.als_flag    = status_reg[asirc_pkg::BIT_ALS_FLAG];
    assign irq.prox_flag   = status_reg[asirc_pkg::BIT_PROX_FLAG];
    assign irq.sat_flag    = status_reg[asirc_pkg::BIT_SAT_FLAG];
    assign irq.als_en      = interrupt_enable_reg[asirc_pkg::BIT_ALS_IRQ_EN];
    assign irq.prox_en     = interrupt_enable_reg[asirc_pkg::BIT_PROX_IRQ_EN];
    assign irq.sat_en      = interrupt_enable_reg[asirc_pkg::BIT_SAT_IRQ_EN];
    assign irq.sleep_after = config_three_reg[asirc_pkg::BIT_SLEEP_AFTER];
    assign irq.power_on    = power_on;
    assign irq.cycle_done  = meas_cycle_done;

    asirc_irq_sleep u_irq_sleep (
        .mclk   (mclk),
        .arst_n (arst_n),
        .irq    (irq.ctrl)
    );

    assign osc_enable = irq.osc_enable;
    // pin pulled low while enabled flag set
    assign int_pin_out  = 1'b0;
    assign int_pin_oe_n = ~irq.irq_active;

    // ----------------------------------------------------------------
    // autozero scheduling
    // ----------------------------------------------------------------
    // count restarts on power-off so the first cycle after power-up gets autozero
    wire az_run = als_cycle_start & irq.osc_enable;
    always_comb
    begin
        az_count_next = az_count_reg;
        az_req_next   = 1'b0;
        if (az_run)
        begin
            if (az_interval == asirc_pkg::AZ_NEVER)
                az_req_next = 1'b0;
            else if (az_interval == asirc_pkg::AZ_FIRST_ONLY)
                az_req_next = az_first_reg;
            else
            begin
                az_req_next = (az_count_reg == asirc_pkg::AZ_COUNT_ZERO);
                if (az_count_reg + asirc_pkg::AZ_COUNT_ONE >= az_interval)
                    az_count_next = asirc_pkg::AZ_COUNT_ZERO;
                else
                    az_count_next = az_count_reg + asirc_pkg::AZ_COUNT_ONE;
            end
        end
        if (!power_on)
            az_count_next = asirc_pkg::AZ_COUNT_ZERO;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            az_count_reg <= asirc_pkg::AZ_COUNT_ZERO;
            az_first_reg <= 1'b1;
            az_req_reg   <= 1'b0;
        end
        else
        begin
            az_count_reg <= az_count_next;
            az_first_reg <= power_on ? (az_first_reg & ~az_run) : 1'b1;
            az_req_reg   <= az_req_next;
        end
    end

    assign autozero_req = az_req_reg;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // power-on still reads back while asleep
    always_comb
    begin
        case (reg_addr)
            asirc_pkg::ADDR_ENABLE:     rdata_next = enable_reg;
            asirc_pkg::ADDR_STATUS:     rdata_next = status_reg;
            asirc_pkg::ADDR_CONFIG3:    rdata_next = config_three_reg;
            asirc_pkg::ADDR_AUTOZERO:   rdata_next = autozero_config_reg;
            asirc_pkg::ADDR_INT_ENABLE: rdata_next = interrupt_enable_reg;
            asirc_pkg::ADDR_VIS_SCALE:  rdata_next = VIS_SCALE;
            default:                    rdata_next = asirc_pkg::READ_ZERO;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= asirc_pkg::READ_ZERO;
        else if (reg_rd_stb)
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

endmodule : asirc_regs
`default_nettype wire

// ==== asirc_regs_sva.sv ====
// port-level checks of the light-sensor configuration register bank
`timescale 1ns/1ps
`default_nettype none
module asirc_regs_sva #(
    parameter logic [7:0] VIS_SCALE = 8'h94
) (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic       reg_wr_stb,
    input wire logic       reg_rd_stb,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       als_thresh_evt,
    input wire logic       prox_thresh_evt,
    input wire logic       afe_sat_evt,
    input wire logic       cal_done_evt,
    input wire logic       meas_cycle_done,
    input wire logic       als_cycle_start,
    input wire logic       autozero_req,
    input wire logic       osc_enable,
    input wire logic       int_pin_out,
    input wire logic       int_pin_oe_n
);
    // ------------------------------------------------------------
    // shadows of host-written controls
    // ------------------------------------------------------------
    logic       pon_q;
    logic [7:0] cfg_q;
    logic [7:0] ie_q;
    logic       rd_st;
    logic       evts;
    assign rd_st = reg_rd_stb && (reg_addr == asirc_pkg::ADDR_STATUS);
    assign evts  = als_thresh_evt | prox_thresh_evt | afe_sat_evt | cal_done_evt;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pon_q <= 1'b0;
            cfg_q <= 8'h4c;
            ie_q  <= 8'h00;
        end
        else if (reg_wr_stb)
        begin
            if (reg_addr == 8'h80)
                pon_q <= reg_wdata[0];
            if (reg_addr == 8'hab)
                cfg_q <= reg_wdata;
            if (reg_addr == 8'hdd)
                ie_q <= reg_wdata;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    rd_hold_a: assert property (!reg_rd_stb |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    vis_read_a: assert property (reg_rd_stb && reg_addr == 8'he6 |=> reg_rdata == VIS_SCALE)
        else $error("scale factor read wrong");
    rd_clear_a: assert property ((rd_st && cfg_q[7] && !evts) ##1 !evts ##1 (rd_st && !evts)
        |=> reg_rdata == 8'h00)
        else $error("status not cleared by read");
    als_irq_a: assert property (als_thresh_evt && ie_q[4] && !reg_wr_stb |=> !int_pin_oe_n)
        else $error("als interrupt not raised");
    sat_irq_a: assert property (afe_sat_evt && ie_q[7] && !reg_wr_stb |=> !int_pin_oe_n)
        else $error("saturation interrupt not raised");
    irq_gate_a: assert property ((ie_q & 8'hb0) == 8'h00 |-> int_pin_oe_n)
        else $error("interrupt with all enables off");
    osc_pon_a: assert property (!pon_q |-> !osc_enable)
        else $error("oscillator on with power-on clear");
    sleep_entry_a: assert property (meas_cycle_done && cfg_q[4] && pon_q && !int_pin_oe_n
        && !reg_wr_stb && !reg_rd_stb |=> !osc_enable)
        else $error("no sleep after interrupt");
    az_cause_a: assert property (autozero_req |-> $past(als_cycle_start) && $past(osc_enable))
        else $error("autozero without a cycle start");
    reset_out_a: assert property ($rose(arst_n) |-> int_pin_oe_n && !osc_enable && !autozero_req)
        else $error("outputs wrong after reset");
endmodule : asirc_regs_sva
bind asirc_regs asirc_regs_sva #(.VIS_SCALE(VIS_SCALE)) u_sva (.mclk(mclk), .arst_n(arst_n),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .als_thresh_evt(als_thresh_evt),
    .prox_thresh_evt(prox_thresh_evt), .afe_sat_evt(afe_sat_evt), .cal_done_evt(cal_done_evt),
    .meas_cycle_done(meas_cycle_done), .als_cycle_start(als_cycle_start),
    .autozero_req(autozero_req), .osc_enable(osc_enable), .int_pin_out(int_pin_out),
    .int_pin_oe_n(int_pin_oe_n));
`default_nettype wire

// ==== asirc_host_model.sv ====
// host side of the register port: single-byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module asirc_host_model (
    input  wire logic       mclk,
    output logic            reg_wr_stb,
    output logic            reg_rd_stb,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 8'h00;
    end
    // ------------------------------------------------------------
    // bus cycles; released address shows its inverted value; write data is inverted after writes, left as is by reads
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr_stb <= 1'b1;
        reg_addr   <= a;
        reg_wdata  <= d;
        @(posedge mclk);
        reg_wr_stb <= 1'b0;
        reg_addr   <= ~a;
        reg_wdata  <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd_stb <= 1'b1;
        reg_addr   <= a;
        @(posedge mclk);
        reg_rd_stb <= 1'b0;
        reg_addr   <= ~a;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd
    task automatic clear_flags(input logic [7:0] m);
        wr(8'h93, m);
    endtask : clear_flags
    function automatic int vis_pct(input logic [7:0] s);
        return s[7] ? -int'(s[6:0]) : int'(s[6:0]);
    endfunction : vis_pct
endmodule : asirc_host_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench of the configuration and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       mclk;
    logic       arst_n;
    logic [5:0] evt;
    logic       wr_stb, rd_stb, az_req, osc_en, pin_out, pin_oe_n;
    logic [7:0] addr, wdata, rdata, d, cnt;
    int         n_fail, n_tests;
    // addr, reset value, write data, read back
    localparam logic [31:0] ROWS [7] = '{32'h80_00_ff_01, 32'h93_00_ff_00, 32'hab_4c_a5_a5,
        32'hd6_7f_85_85, 32'hdd_00_91_91, 32'he6_94_00_94, 32'h3c_00_ff_00};
    // interval, autozero runs in seven cycles
    localparam logic [15:0] AZ [3] = '{16'h7f_01, 16'h00_00, 16'h03_03};
    asirc_regs uut (.mclk(mclk), .arst_n(arst_n), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .als_thresh_evt(evt[0]),
        .prox_thresh_evt(evt[1]), .afe_sat_evt(evt[2]), .cal_done_evt(evt[3]),
        .meas_cycle_done(evt[4]), .als_cycle_start(evt[5]), .autozero_req(az_req),
        .osc_enable(osc_en), .int_pin_out(pin_out), .int_pin_oe_n(pin_oe_n));
    asirc_host_model host (.mclk(mclk), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask : chk1
    task automatic pulse(input logic [5:0] m);
        @(posedge mclk);
        evt <= m;
        @(posedge mclk);
        evt <= 6'h00;
        @(negedge mclk);
    endtask : pulse
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        arst_n  = 1'b0;
        evt     = 6'h00;
        n_fail  = 0;
        n_tests = 0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        foreach (ROWS[i])
        begin
            host.rd(ROWS[i][31:24], d);
            chk8("reset value", ROWS[i][23:16], d);
            host.wr(ROWS[i][31:24], ROWS[i][15:8]);
            host.rd(ROWS[i][31:24], d);
            chk8("read back", ROWS[i][7:0], d);
        end
        host.rd(8'he6, d);
        chk8("scale percent", 8'hec, 8'(host.vis_pct(d)));
        pulse(6'h01);
        chk1("irq pin", 1'b0, pin_oe_n);
        chk1("pin level", 1'b0, pin_out);
        host.rd(8'h93, d);
        chk8("status", 8'h10, d);
        host.rd(8'h93, d);
        chk8("status reread", 8'h00, d);
        chk1("irq pin", 1'b1, pin_oe_n);
        host.wr(8'hab, 8'h4c);
        host.wr(8'hdd, 8'h10);
        pulse(6'h0e);
        chk1("irq pin", 1'b1, pin_oe_n);
        host.rd(8'h93, d);
        chk8("status", 8'ha8, d);
        host.wr(8'hdd, 8'h20);
        @(negedge mclk);
        chk1("prox irq pin", 1'b0, pin_oe_n);
        host.wr(8'hdd, 8'h90);
        @(negedge mclk);
        chk1("irq pin", 1'b0, pin_oe_n);
        host.clear_flags(8'ha8);
        @(negedge mclk);
        chk1("irq pin", 1'b1, pin_oe_n);
        host.wr(8'hab, 8'h5c);
        pulse(6'h01);
        chk1("osc before cycle end", 1'b1, osc_en);
        pulse(6'h10);
        chk1("osc asleep", 1'b0, osc_en);
        host.rd(8'h80, d);
        chk8("power on bit", 8'h01, d);
        host.clear_flags(8'h10);
        @(posedge mclk);
        @(negedge mclk);
        chk1("osc awake", 1'b1, osc_en);
        foreach (AZ[j])
        begin
            host.wr(8'h80, 8'h00);
            @(negedge mclk);
            chk1("osc off", 1'b0, osc_en);
            host.wr(8'h80, 8'h01);
            host.wr(8'hd6, AZ[j][15:8]);
            cnt = 8'h00;
            repeat (7)
            begin
                pulse(6'h20);
                if (az_req === 1'b1)
                    cnt++;
            end
            chk8("autozero count", AZ[j][7:0], cnt);
        end
        @(posedge mclk);
        arst_n <= 1'b0;
        @(negedge mclk);
        chk1("pin in reset", 1'b1, pin_oe_n);
        chk1("osc in reset", 1'b0, osc_en);
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        host.rd(8'hd6, d);
        chk8("autozero after reset", 8'h7f, d);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
